// File: rtl/tmw_pkg.sv
// Package with register map, field positions and reset values of the timer mode/control block
package tmw_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFFSET    = 4'h0;
  localparam logic [3:0] CONTROL_OFFSET = 4'h4;
  localparam logic [3:0] COUNT_OFFSET   = 4'h8;
  localparam logic [3:0] GRA_OFFSET     = 4'hC;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_RUN_BIT   = 7;
  localparam int MODE_BUFB_BIT  = 5;
  localparam int MODE_BUFA_BIT  = 4;
  localparam int MODE_PWM_SELECT_D_BIT  = 2;
  localparam int MODE_PWM_SELECT_C_BIT  = 1;
  localparam int MODE_PWM_SELECT_B_BIT  = 0;
  localparam logic [7:0] MODE_RSVD_MASK  = 8'h48;
  localparam logic [7:0] MODE_RESET      = 8'h48;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_CLR_BIT    = 7;
  localparam int CTRL_CKS_HI     = 6;
  localparam int CTRL_CKS_LO     = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH = 16;
  localparam int PRESCALE_WIDTH = 3;

endpackage : tmw_pkg

// File: rtl/tmw_prescaler.sv
// Prescaler producing one-cycle enables at clock/2, /4 and /8
module tmw_prescaler #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Enable pulses
  output logic [WIDTH-1:0]      tick_o
);

  logic [WIDTH-1:0] div_count;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_count <= '0;
    else
      div_count <= div_count + 1'b1;
  end

  // Bit k pulses once every 2^(k+1) cycles
  for (genvar k = 0; k < WIDTH; k++)
  begin : g_tick
    assign tick_o[k] = &div_count[k:0];
  end

endmodule // tmw_prescaler

// File: rtl/tmw_timer_ctrl.sv
// Timer mode and control registers with counter, clock select and channel outputs
//
// Contract
// R1 - Mode bit 7 zero halts the counter; one lets it advance on the selected clock.
// R2 - Mode bits 6 and 3 always read one; writes to them are ignored.
// R3 - Mode bit 5 makes general register D the buffer for B.
// R4 - Mode bit 4 makes general register C the buffer for A.
// R5 - Mode bits 2,1,0 select PWM output for pins D, C and B.
// R6 - Control bit 7 set clears the counter on compare match with general register A.
// R7 - Control bit 7 clear lets the counter run freely and wrap.
// R8 - Clock select 000 system clock, 001 half, 010 quarter, 011 eighth.
// R9 - Clock select top bit set counts rising edges of the external event pin.
// R10 - Undivided clock in low-speed modes counts subclock cycles instead.
// R11 - Control bits 3..0 set each channel pin level until its first compare match.
// R12 - Writing an initial level bit changes the pin output immediately.
// R13 - The counter is a 16-bit up-counter compared with the general registers.
// R14 - The external event pin is synchronised and each rising edge counts once.
module tmw_timer_ctrl #(
  parameter int COUNT_WIDTH = tmw_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [3:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  // Low-speed operation
  input  wire logic                   sub_mode_i,
  input  wire logic                   sub_tick_i,
  // External event pin
  input  wire logic                   ext_event_pin_i,
  // Channel pins and mode indications
  output logic [3:0]                  channel_pin_o,
  output logic [3:0]                  channel_pin_oe_n_o,
  output logic                        buffer_pair_a_enable_o,
  output logic                        buffer_pair_b_enable_o,
  output logic [2:0]                  pwm_select_o,
  output logic [COUNT_WIDTH-1:0]      timer_count_o
);

  // ----------------------------------------------------------------
  // Registers and signals
  // ----------------------------------------------------------------
  logic [7:0]             timer_mode_reg;
  logic [7:0]             timer_control_reg;
  logic [COUNT_WIDTH-1:0] timer_count;
  logic [COUNT_WIDTH-1:0] general_reg_a;
  logic [3:0]             chan_match;
  wire logic [3:0]        pin_level;
  logic [2:0]             prescale_tick;
  logic                   event_sync1;
  logic                   event_sync2;
  logic                   event_prev;
  logic                   event_rise;
  logic                   count_enable;
  logic                   match_a;
  logic                   req;
  logic                   wr_lane0;
  logic                   wr_lane1;
  logic [2:0]             clock_select;
  logic [31:0]            next_dat;
  logic                   wr_mode;
  logic                   wr_control;
  logic                   wr_count;
  logic                   count_step;
  logic                   match_event;

  assign req          = cyc_i && stb_i && !ack_o;
  assign wr_lane0     = req && we_i && sel_i[0];
  assign wr_lane1     = req && we_i && sel_i[1];
  assign clock_select = timer_control_reg[tmw_pkg::CTRL_CKS_HI:tmw_pkg::CTRL_CKS_LO];

  // Register write strobes, on the edge that raises ack
  assign wr_mode      = wr_lane0 && adr_i == tmw_pkg::MODE_OFFSET;
  assign wr_control   = wr_lane0 && adr_i == tmw_pkg::CONTROL_OFFSET;
  assign wr_count     = req && we_i && adr_i == tmw_pkg::COUNT_OFFSET && sel_i[1:0] == 2'h3;

  // ----------------------------------------------------------------
  // Wishbone handshake: ack one cycle after request, then drop
  // ----------------------------------------------------------------
  // Gating with ack keeps a held request from being taken twice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  always_comb
  begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      tmw_pkg::MODE_OFFSET:    next_dat[7:0] = timer_mode_reg | tmw_pkg::MODE_RSVD_MASK; // R2
      tmw_pkg::CONTROL_OFFSET: next_dat[7:0] = timer_control_reg;
      tmw_pkg::COUNT_OFFSET:   next_dat[COUNT_WIDTH-1:0] = timer_count;
      tmw_pkg::GRA_OFFSET:     next_dat[COUNT_WIDTH-1:0] = general_reg_a;
      default:                 next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (req && !we_i)
      dat_o <= next_dat;
  end

  // ----------------------------------------------------------------
  // Mode and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_mode_reg <= tmw_pkg::MODE_RESET;
    else if (wr_mode)
      timer_mode_reg <= dat_i[7:0] | tmw_pkg::MODE_RSVD_MASK; // R2
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_control_reg <= tmw_pkg::CTRL_RESET;
    else if (wr_control)
      timer_control_reg <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      general_reg_a <= '1;
    else if (adr_i == tmw_pkg::GRA_OFFSET)
    begin
      if (wr_lane0)
        general_reg_a[7:0] <= dat_i[7:0];
      if (wr_lane1)
        general_reg_a[15:8] <= dat_i[15:8];
    end
  end

  assign buffer_pair_b_enable_o = timer_mode_reg[tmw_pkg::MODE_BUFB_BIT]; // R3
  assign buffer_pair_a_enable_o = timer_mode_reg[tmw_pkg::MODE_BUFA_BIT]; // R4
  assign pwm_select_o = {timer_mode_reg[tmw_pkg::MODE_PWM_SELECT_D_BIT],
                         timer_mode_reg[tmw_pkg::MODE_PWM_SELECT_C_BIT],
                         timer_mode_reg[tmw_pkg::MODE_PWM_SELECT_B_BIT]}; // R5

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  // Free-running divider: the first step after a select change may come early
  tmw_prescaler #(
    .WIDTH (tmw_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (prescale_tick)
  );

  // Two flops against metastability, a third holds the old level for edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      event_sync1 <= 1'b0;
      event_sync2 <= 1'b0;
      event_prev  <= 1'b0;
    end
    else
    begin
      event_sync1 <= ext_event_pin_i; // R14
      event_sync2 <= event_sync1;
      event_prev  <= event_sync2;
    end
  end

  assign event_rise = event_sync2 && !event_prev; // R14

  always_comb
  begin
    count_enable = 1'b0;
    if (clock_select[2])
      count_enable = event_rise; // R9
    else
    begin
      unique case (clock_select[1:0])
        2'h0: count_enable = sub_mode_i ? sub_tick_i : 1'b1; // R8 R10
        2'h1: count_enable = prescale_tick[0]; // R8
        2'h2: count_enable = prescale_tick[1]; // R8
        2'h3: count_enable = prescale_tick[2]; // R8
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign match_a     = (timer_count == general_reg_a); // R13
  assign count_step  = timer_mode_reg[tmw_pkg::MODE_RUN_BIT] && count_enable; // R1
  assign match_event = count_step && match_a;

  // A software write wins over a count step in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_count <= '0;
    else if (wr_count)
      timer_count <= dat_i[COUNT_WIDTH-1:0];
    else if (count_step) // R1
    begin
      // Clearing on the match step gives a period of general_reg_a plus one
      if (timer_control_reg[tmw_pkg::CTRL_CLR_BIT] && match_a)
        timer_count <= '0; // R6
      else
        timer_count <= timer_count + 1'b1; // R7 R13
    end
  end

  assign timer_count_o = timer_count;

  // ----------------------------------------------------------------
  // Channel output levels
  // ----------------------------------------------------------------
  // Only channel A's compare match is known here; the matches of B, C
  // and D belong to the datapath outside this block.
  assign chan_match = {3'h0, match_event};

  // Each channel follows its level bit until its first compare match;
  // a control write re-arms every channel.
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_channel
    logic seen;
    logic level;

    // A match in the same cycle as a control write still counts
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        seen <= 1'b0;
      else if (chan_match[ch])
        seen <= 1'b1;
      else if (wr_control)
        seen <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        level <= 1'b0;
      else if (wr_control)
        level <= dat_i[ch]; // R12
      else if (!seen)
        level <= timer_control_reg[ch]; // R11
    end

    assign pin_level[ch] = level;
  end : g_channel

  assign channel_pin_o      = pin_level;
  // The pins are always driven from this block
  assign channel_pin_oe_n_o = 4'h0;

endmodule // tmw_timer_ctrl

// File: testbench/tmw_timer_ctrl_props.sv
// Assertion checker for the timer mode and control block
module tmw_timer_ctrl_props (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Timer side
  input wire logic        sub_mode_i,
  input wire logic [3:0]  channel_pin_o,
  input wire logic        buffer_pair_a_enable_o,
  input wire logic        buffer_pair_b_enable_o,
  input wire logic [2:0]  pwm_select_o,
  input wire logic [15:0] timer_count_o
);
  // ----
  // Shadows of the run bit and control bits 7..4
  // ----
  logic       acc;
  logic       take;
  logic       wr_mode;
  logic       wr_ctl;
  logic       wr_cnt;
  logic       run_on;
  logic [3:0] ctl_bits;
  assign acc = cyc_i && stb_i && ack_o;
  // Writes land on the edge that takes the request
  assign take = cyc_i && stb_i && !ack_o;
  assign wr_mode = take && we_i && adr_i == tmw_pkg::MODE_OFFSET && sel_i[0];
  assign wr_ctl = take && we_i && adr_i == tmw_pkg::CONTROL_OFFSET && sel_i[0];
  assign wr_cnt = take && we_i && adr_i == tmw_pkg::COUNT_OFFSET;
  always_ff @(posedge clk_i)
    if (rst_i)
      run_on <= 1'b0;
    else if (wr_mode)
      run_on <= dat_i[7];
  always_ff @(posedge clk_i)
    if (rst_i)
      ctl_bits <= 4'h0;
    else if (wr_ctl)
      ctl_bits <= dat_i[7:4];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  rsvd_read_a: assert property (acc && !we_i && adr_i == tmw_pkg::MODE_OFFSET
    |-> dat_o[6] && dat_o[3]) else $error("reserved mode bits read zero");
  buf_b_a: assert property (wr_mode |=> buffer_pair_b_enable_o == $past(dat_i[5]))
    else $error("buffer pair b not set");
  buf_a_a: assert property (wr_mode |=> buffer_pair_a_enable_o == $past(dat_i[4]))
    else $error("buffer pair a not set");
  pwm_mode_a: assert property (wr_mode |=> pwm_select_o == $past(dat_i[2:0]))
    else $error("pwm select not set");
  level_set_a: assert property (wr_ctl |=> channel_pin_o == $past(dat_i[3:0]))
    else $error("initial level not on pins");
  count_halt_a: assert property (!run_on && !wr_cnt |=> $stable(timer_count_o))
    else $error("counter moved while halted");
  count_step_a: assert property (run_on && ctl_bits == 4'h0 && !sub_mode_i && !wr_cnt
    |=> timer_count_o == $past(timer_count_o) + 16'h1) else $error("counter step wrong");
  run_start_c: cover property (wr_mode && dat_i[7]);
  count_read_c: cover property (acc && !we_i && adr_i == tmw_pkg::COUNT_OFFSET);
  event_mode_c: cover property (run_on && ctl_bits[2] && timer_count_o != 16'h0);
  clear_wrap_c: cover property (run_on && ctl_bits[3] && timer_count_o == 16'h3
    ##1 timer_count_o == 16'h0);
endmodule // tmw_timer_ctrl_props

bind tmw_timer_ctrl tmw_timer_ctrl_props u_tmw_timer_ctrl_props (.*);

// File: testbench/tmw_timer_ctrl_bench.sv
// Self-checking bench for the timer mode and control block
module tmw_timer_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} tmw_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        sub_mode_i = 1'b0;
  logic        sub_tick_i = 1'b0;
  logic        ext_event_pin_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [3:0]  channel_pin_o;
  logic [3:0]  channel_pin_oe_n_o;
  logic [15:0] timer_count_o;
  logic [31:0] rd;
  logic [31:0] exp;
  int          errors = 0;
  int          comparisons = 0;
  tmw_row_t    rows [6] = '{'{4'h0, 8'h37, 8'h7F}, '{4'h0, 8'h00, 8'h48},
    '{4'h4, 8'h0F, 8'h0F}, '{4'h4, 8'h0A, 8'h0A}, '{4'h1, 8'hFF, 8'h00},
    '{4'hC, 8'h5A, 8'h5A}};
  tmw_timer_ctrl u_tmw_timer_ctrl (.*, .buffer_pair_a_enable_o(), .buffer_pair_b_enable_o(),
    .pwm_select_o());
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) sub_tick_i <= ~sub_tick_i;
  // ----
  // Bus cycle, compare and verdict
  // ----
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({28'h0, channel_pin_o}, 32'h0);
    chk({28'h0, channel_pin_oe_n_o}, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h48);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, {24'h0, rows[i].d});
      if (rows[i].a == 4'h4)
        chk({28'h0, channel_pin_o}, {28'h0, rows[i].d[3:0]});
      bus(1'b0, rows[i].a, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, rows[i].e});
    end
    for (int c = 0; c < 5; c++)
    begin
      sub_mode_i <= (c == 4);
      bus(1'b1, 4'h4, {26'h0, c[1:0], 4'h0});
      bus(1'b1, 4'h8, 32'h0);
      bus(1'b1, 4'h0, 32'h80);
      repeat (64) @(posedge clk_i);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      exp = 32'h43 >> ((c == 4) ? 1 : c);
      if (c > 0 && rd === exp + 32'h1)
        exp = rd;
      chk(rd, exp);
    end
    sub_mode_i <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 4'h4, (k == 0) ? 32'h70 : 32'h40);
      bus(1'b1, 4'h8, 32'h0);
      bus(1'b1, 4'h0, 32'h80);
      repeat (5)
      begin
        ext_event_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_event_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h5);
      bus(1'b1, 4'h0, 32'h0);
    end
    bus(1'b1, 4'hC, 32'h3);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'h4, 32'h80);
    bus(1'b1, 4'h0, 32'h80);
    repeat (20)
    begin
      @(posedge clk_i);
      chk({31'h0, timer_count_o > 16'h3}, 32'h0);
    end
    bus(1'b1, 4'h4, 32'h85);
    chk({28'h0, channel_pin_o}, 32'h5);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, channel_pin_o}, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h48);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule // tmw_timer_ctrl_bench
